// [verilog/mdcfg_map.svh]
// Register map, field positions and reset values for the mode, link and
// scratch configuration bank. Assumes a host link engine outside.
// Function
// - Action 00: straight to high-impedance power-down
// - Action 01: jump to stored code, then power-down
// - Action 10: slew to margin-low, then power-down
// - Action 11: slew to margin-high, then power-down
// - Link bit 8 enables PMBus operation
// - Link bit 2 selects fast readback timing
// - Link bit 0 drives readback onto pin
// - Pointer write selects next scratch location
// - Pointer increments after every scratch write
// - Operating config also at page FFh, E9h
// - Scratch pointer also at page FFh, EFh
// - Pin function 0101 falling edge fires protect
// - Scratch data register accesses pointed location
`ifndef MDCFG_MAP_SVH
`define MDCFG_MAP_SVH

// ----------------------------------------------------------------------
// Direct register addresses
// ----------------------------------------------------------------------
`define MDCFG_ADR_OPCFG 8'h25
`define MDCFG_ADR_LINK 8'h26
`define MDCFG_ADR_SPTR 8'h2b
`define MDCFG_ADR_SDATA 8'h2c

// ----------------------------------------------------------------------
// PMBus page and command codes
// ----------------------------------------------------------------------
`define MDCFG_PMB_PAGE 8'hff
`define MDCFG_PMB_OPCFG 8'he9
`define MDCFG_PMB_SPTR 8'hef
`define MDCFG_PMB_SDATA 8'hf0

// ----------------------------------------------------------------------
// Field positions and values
// ----------------------------------------------------------------------
`define MDCFG_BIT_LOWPWR 13
`define MDCFG_BIT_TMO 12
`define MDCFG_BIT_PMB 8
`define MDCFG_BIT_ACT_HI 9
`define MDCFG_BIT_ACT_LO 8
`define MDCFG_BIT_FAST 2
`define MDCFG_BIT_RDBK 0
`define MDCFG_LINK_MASK 16'h1105
`define MDCFG_FUNC_PROTECT 4'h5
`define MDCFG_RST_16 16'h0000
`define MDCFG_RST_8 8'h00

`endif

// [verilog/mdcfg_pkg.sv]
// Types shared by the configuration bank.
// Assumes the map header supplies every number.
package mdcfg_pkg;

  // One host access, already decoded to a 16-bit register word.
  typedef struct packed {
    logic wr;
    logic rd;
    logic pmb;
    logic [7:0] page;
    logic [7:0] addr;
    logic [15:0] wdata;
  } mdcfg_acc_s;

  // Register selected by an access.
  typedef enum logic [2:0] {
    MDCFG_SEL_NONE = 3'h0,
    MDCFG_SEL_OPCFG = 3'h1,
    MDCFG_SEL_LINK = 3'h2,
    MDCFG_SEL_SPTR = 3'h3,
    MDCFG_SEL_SDATA = 3'h4
  } mdcfg_sel_e;

  // Protect sequencer states, one-hot.
  typedef enum logic [3:0] {
    MDCFG_ST_IDLE = 4'b0001,
    MDCFG_ST_JUMP = 4'b0010,
    MDCFG_ST_SLEW = 4'b0100,
    MDCFG_ST_PDN = 4'b1000
  } mdcfg_st_e;

  // Output code target handed to the channel datapath.
  typedef enum logic [1:0] {
    MDCFG_TGT_NONE = 2'h0,
    MDCFG_TGT_NVM = 2'h1,
    MDCFG_TGT_MLOW = 2'h2,
    MDCFG_TGT_MHIGH = 2'h3
  } mdcfg_tgt_e;

endpackage

// [verilog/mdcfg_regs.sv]
// Operating, host link and scratch pointer registers, the scratch memory
// and the protect sequencer. Assumes a link engine presents one decoded
// access per cycle and the channel datapath reports slew completion.
`timescale 1ns/10ps
`include "mdcfg_map.svh"

module mdcfg_regs
  import mdcfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire mdcfg_acc_s i_acc,
  input wire logic i_gp_pin,
  input wire logic [3:0] i_pin_input_function,
  input wire logic i_slew_done,
  output logic [15:0] o_rdata,
  output logic o_rvalid,
  output logic o_low_power_select,
  output logic o_timeout_en,
  output logic o_pmbus_en,
  output logic o_fast_readback_enable,
  output logic o_readback_output_enable,
  output mdcfg_tgt_e o_tgt,
  output logic o_slew_req,
  output logic o_hiz_pdn
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------

  // Maps an access to a register; PMBus form is honoured only when enabled.
  function automatic mdcfg_sel_e dec(input mdcfg_acc_s a, input logic pmb_on);
    dec = MDCFG_SEL_NONE;
    if (!a.pmb) begin
      unique case (a.addr)
        `MDCFG_ADR_OPCFG: dec = MDCFG_SEL_OPCFG;
        `MDCFG_ADR_LINK: dec = MDCFG_SEL_LINK;
        `MDCFG_ADR_SPTR: dec = MDCFG_SEL_SPTR;
        `MDCFG_ADR_SDATA: dec = MDCFG_SEL_SDATA;
        default: dec = MDCFG_SEL_NONE;
      endcase
    end else if (pmb_on && a.page == `MDCFG_PMB_PAGE) begin
      // The link register has no PMBus command, so it stays direct only.
      unique case (a.addr)
        `MDCFG_PMB_OPCFG: dec = MDCFG_SEL_OPCFG;
        `MDCFG_PMB_SPTR: dec = MDCFG_SEL_SPTR;
        `MDCFG_PMB_SDATA: dec = MDCFG_SEL_SDATA;
        default: dec = MDCFG_SEL_NONE;
      endcase
    end
  endfunction

  logic [15:0] opcfg_ff; // Operating configuration, all bits stored.
  logic [15:0] link_ff; // Host link configuration, writable bits only.
  logic [7:0] sptr_ff; // Scratch memory pointer.
  logic [15:0] scratch_mem [0:255]; // Scratch memory, no reset.
  mdcfg_sel_e sel; // Register hit by this cycle's access.
  logic wr_op; // Write to the operating configuration.
  logic wr_sdata; // Write into scratch memory.

  // PMBus-form accesses decode only while PMBus operation is enabled.
  // PMBus address aliases
  assign sel = dec(i_acc, link_ff[`MDCFG_BIT_PMB]);
  assign wr_op = i_acc.wr && sel == MDCFG_SEL_OPCFG;
  assign wr_sdata = i_acc.wr && sel == MDCFG_SEL_SDATA;

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------

  // Reserved bits are kept as written; software is expected to write zeros.
  // Stored as written
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      opcfg_ff <= `MDCFG_RST_16;
    end else if (wr_op) begin
      opcfg_ff <= i_acc.wdata;
    end
  end

  // Only the four defined bits hold state; the rest read back as zero.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      link_ff <= `MDCFG_RST_16;
    end else if (i_acc.wr && sel == MDCFG_SEL_LINK) begin
      link_ff <= i_acc.wdata & `MDCFG_LINK_MASK;
    end
  end

  // Pointer load wins over the increment; a data write bumps it by one.
  // Pointer load, increment
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      sptr_ff <= `MDCFG_RST_8;
    end else if (i_acc.wr && sel == MDCFG_SEL_SPTR) begin
      sptr_ff <= i_acc.wdata[7:0];
    end else if (wr_sdata) begin
      sptr_ff <= sptr_ff + 8'h01;
    end
  end

  // Scratch memory has no reset so it can map onto a RAM macro.
  // Scratch data write
  always_ff @(posedge i_clk) begin
    if (wr_sdata) begin
      scratch_mem[sptr_ff] <= i_acc.wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------

  // Read data is registered and valid one cycle after the request.
  // Reads of scratch data leave the pointer where it is.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_rdata <= `MDCFG_RST_16;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_acc.rd;
      unique case (sel)
        MDCFG_SEL_OPCFG: o_rdata <= opcfg_ff;
        MDCFG_SEL_LINK: o_rdata <= link_ff;
        MDCFG_SEL_SPTR: o_rdata <= {8'h00, sptr_ff};
        MDCFG_SEL_SDATA: o_rdata <= scratch_mem[sptr_ff];
        default: o_rdata <= `MDCFG_RST_16;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------------

  assign o_timeout_en = link_ff[`MDCFG_BIT_TMO];
  assign o_pmbus_en = link_ff[`MDCFG_BIT_PMB];
  assign o_fast_readback_enable = link_ff[`MDCFG_BIT_FAST];
  assign o_readback_output_enable = link_ff[`MDCFG_BIT_RDBK];
  assign o_low_power_select = opcfg_ff[`MDCFG_BIT_LOWPWR];

  // ----------------------------------------------------------------------
  // Protect trigger
  // ----------------------------------------------------------------------

  logic pin_ff; // Pin level one cycle ago.
  logic trig; // Falling edge while the pin acts as protect input.

  // Reset to high, so a pin held low through reset fires an edge once reset lifts.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      pin_ff <= 1'b1;
    end else begin
      pin_ff <= i_gp_pin;
    end
  end

  assign trig = pin_ff && !i_gp_pin && i_pin_input_function == `MDCFG_FUNC_PROTECT;

  // ----------------------------------------------------------------------
  // Protect sequencer
  // ----------------------------------------------------------------------

  mdcfg_st_e st_ff; // Sequencer state.
  mdcfg_st_e nxt_st; // Next sequencer state.
  mdcfg_tgt_e tgt_ff; // Code target latched at the trigger.
  logic [1:0] act; // Protect action field.

  assign act = opcfg_ff[`MDCFG_BIT_ACT_HI:`MDCFG_BIT_ACT_LO];

  // Power-down holds until software rewrites the operating configuration.
  // Edges during a running sequence are ignored.
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      MDCFG_ST_IDLE: begin
        if (trig) begin
          unique case (act)
            2'b00: nxt_st = MDCFG_ST_PDN;
            2'b01: nxt_st = MDCFG_ST_JUMP;
            default: nxt_st = MDCFG_ST_SLEW;
          endcase
        end
      end
      MDCFG_ST_JUMP: nxt_st = MDCFG_ST_PDN;
      MDCFG_ST_SLEW: begin
        if (i_slew_done) begin
          nxt_st = MDCFG_ST_PDN;
        end
      end
      MDCFG_ST_PDN: begin
        if (wr_op) begin
          nxt_st = MDCFG_ST_IDLE;
        end
      end
      default: nxt_st = MDCFG_ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_ff <= MDCFG_ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // The target is held from the trigger through power-down.
  // Target code select
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      tgt_ff <= MDCFG_TGT_NONE;
    end else if (st_ff == MDCFG_ST_IDLE && trig) begin
      unique case (act)
        2'b00: tgt_ff <= MDCFG_TGT_NONE;
        2'b01: tgt_ff <= MDCFG_TGT_NVM;
        2'b10: tgt_ff <= MDCFG_TGT_MLOW;
        default: tgt_ff <= MDCFG_TGT_MHIGH;
      endcase
    end else if (st_ff == MDCFG_ST_PDN && wr_op) begin
      tgt_ff <= MDCFG_TGT_NONE;
    end
  end

  assign o_tgt = tgt_ff;
  assign o_slew_req = st_ff == MDCFG_ST_SLEW;
  assign o_hiz_pdn = st_ff == MDCFG_ST_PDN;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  a_pdn_direct: assert property (
    st_ff == MDCFG_ST_IDLE && trig && act == 2'b00 |=> o_hiz_pdn && !o_slew_req)
    else $error("Action 00 did not enter power-down at once");

  a_jump_nvm: assert property (
    st_ff == MDCFG_ST_IDLE && trig && act == 2'b01
    |=> o_tgt == MDCFG_TGT_NVM && !o_slew_req && !o_hiz_pdn ##1 o_hiz_pdn)
    else $error("Action 01 did not jump then power down");

  a_slew_low: assert property (
    st_ff == MDCFG_ST_IDLE && trig && act == 2'b10
    |=> o_slew_req && o_tgt == MDCFG_TGT_MLOW)
    else $error("Action 10 did not slew to margin-low");

  a_slew_high: assert property (
    st_ff == MDCFG_ST_IDLE && trig && act == 2'b11
    |=> o_slew_req && o_tgt == MDCFG_TGT_MHIGH)
    else $error("Action 11 did not slew to margin-high");

  a_slew_ends: assert property (
    o_slew_req && i_slew_done |=> o_hiz_pdn && !o_slew_req)
    else $error("Slew completion did not lead to power-down");

  a_timeout_wr: assert property (
    i_acc.wr && !i_acc.pmb && i_acc.addr == `MDCFG_ADR_LINK
    |=> o_timeout_en == $past(i_acc.wdata[`MDCFG_BIT_TMO]))
    else $error("Timeout enable did not follow link write");

  a_pmbus_gate: assert property (
    !o_pmbus_en && i_acc.pmb && i_acc.wr |=> $stable(opcfg_ff) && $stable(sptr_ff))
    else $error("PMBus access acted while PMBus disabled");

  a_fast_sel: assert property (
    i_acc.wr && !i_acc.pmb && i_acc.addr == `MDCFG_ADR_LINK
    |=> o_fast_readback_enable == $past(i_acc.wdata[`MDCFG_BIT_FAST]))
    else $error("Fast readback select did not follow link write");

  a_rdbk_pin: assert property (
    i_acc.wr && !i_acc.pmb && i_acc.addr == `MDCFG_ADR_LINK
    |=> o_readback_output_enable == $past(i_acc.wdata[`MDCFG_BIT_RDBK]))
    else $error("Readback drive did not follow link write");

  a_ptr_load: assert property (
    i_acc.wr && sel == MDCFG_SEL_SPTR |=> sptr_ff == $past(i_acc.wdata[7:0]))
    else $error("Pointer write did not load pointer");

  a_ptr_incr: assert property (
    wr_sdata |=> sptr_ff == $past(sptr_ff) + 8'h01)
    else $error("Pointer did not increment after scratch write");

  a_pmb_opcfg: assert property (
    o_pmbus_en && i_acc.wr && i_acc.pmb && i_acc.page == `MDCFG_PMB_PAGE
    && i_acc.addr == `MDCFG_PMB_OPCFG |=> opcfg_ff == $past(i_acc.wdata))
    else $error("PMBus write to operating config was lost");

  a_pmb_sptr: assert property (
    o_pmbus_en && i_acc.wr && i_acc.pmb && i_acc.page == `MDCFG_PMB_PAGE
    && i_acc.addr == `MDCFG_PMB_SPTR |=> sptr_ff == $past(i_acc.wdata[7:0]))
    else $error("PMBus write to scratch pointer was lost");

  a_trig_func: assert property (
    st_ff == MDCFG_ST_IDLE && i_pin_input_function != `MDCFG_FUNC_PROTECT
    |=> st_ff == MDCFG_ST_IDLE)
    else $error("Protect fired with another pin function");

  a_scratch_wr: assert property (
    wr_sdata |=> scratch_mem[$past(sptr_ff)] == $past(i_acc.wdata))
    else $error("Scratch write missed the pointed location");

  a_scratch_rd: assert property (
    i_acc.rd && !i_acc.wr && sel == MDCFG_SEL_SDATA |=> o_rvalid && $stable(sptr_ff))
    else $error("Scratch read moved the pointer or gave no answer");

endmodule

// [test/mdcfg_host.sv]
// Host controller model that issues decoded register accesses to the bank.
// Assumes a shared clock and a read answer one cycle after the access.
`timescale 1ns/10ps
`include "mdcfg_map.svh"

module mdcfg_host
  import mdcfg_pkg::*;
(
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  input wire logic i_rvalid,
  output mdcfg_acc_s o_acc
);
  // ----------------------------------------------------------------
  // Access engine
  // ----------------------------------------------------------------
  // The bus starts idle with no strobe raised.
  initial begin
    o_acc = '0;
  end

  // One access is held for one edge, then the answer is taken.
  // Released fields show the inverse of the last word, so stale data never looks valid.
  task automatic xfer(input logic w, input logic r, input logic p, input logic [7:0] ad,
      input logic [15:0] d, output logic [15:0] q, output logic v);
    logic [15:0] dd;
    begin
      dd = d;
      if (w && ad == (p ? `MDCFG_PMB_OPCFG : `MDCFG_ADR_OPCFG)) begin
        dd = d & 16'h231f;
      end
      @(posedge i_clk);
      o_acc <= '{wr: w, rd: r, pmb: p, page: 8'hff, addr: ad, wdata: dd};
      @(posedge i_clk);
      o_acc <= '{wr: 1'b0, rd: 1'b0, pmb: ~p, page: 8'h00, addr: ~ad, wdata: ~dd};
      @(negedge i_clk);
      q = i_rdata;
      v = i_rvalid;
    end
  endtask
endmodule

// [test/mode_interface_sram_config_tb.sv]
// Self-checking bench for the mode, link and scratch configuration bank.
// Assumes the host model drives the access port; pin and slew inputs are driven here.
`timescale 1ns/10ps

module mode_interface_sram_config_tb
  import mdcfg_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_reset_n;
  mdcfg_acc_s acc;
  logic gp_pin;
  logic [3:0] pin_fn;
  logic slew_done;
  logic [15:0] rdata;
  logic rvalid, low_pwr, tmo_en, pmb_en, fast_en, rdbk_en, slew_req, hiz;
  mdcfg_tgt_e tgt;
  int error_cnt;
  int cmp_count;

  // Clock of 25 ns period.
  always #12.5 i_clk = ~i_clk;

  mdcfg_regs DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_acc(acc), .i_gp_pin(gp_pin),
    .i_pin_input_function(pin_fn), .i_slew_done(slew_done), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_low_power_select(low_pwr), .o_timeout_en(tmo_en),
    .o_pmbus_en(pmb_en), .o_fast_readback_enable(fast_en),
    .o_readback_output_enable(rdbk_en), .o_tgt(tgt), .o_slew_req(slew_req), .o_hiz_pdn(hiz));

  mdcfg_host host (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_acc(acc));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Word comparison; flags are widened by the caller.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic p, input logic [7:0] ad, input logic [15:0] d);
    logic [15:0] q;
    logic v;
    host.xfer(1'b1, 1'b0, p, ad, d, q, v);
  endtask

  // A read must be answered with the valid pulse and the expected word.
  task automatic rd(input logic p, input logic [7:0] ad, input logic [15:0] exp);
    logic [15:0] q;
    logic v;
    host.xfer(1'b0, 1'b1, p, ad, 16'h0000, q, v);
    chk({15'h0000, v}, 16'h0001);
    chk(q, exp);
  endtask

  // The verdict is printed from this one place only.
  task automatic close_out();
    $display("Counts: comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    int i;
    logic [3:0] en;
    logic [3:0] pos [4] = '{4'hc, 4'h8, 4'h2, 4'h0};
    rd(1'b0, 8'h25, 16'h0000);
    rd(1'b0, 8'h26, 16'h0000);
    rd(1'b0, 8'h2b, 16'h0000);
    wr(1'b0, 8'h25, 16'h231f);
    rd(1'b0, 8'h25, 16'h231f);
    chk({15'h0000, low_pwr}, 16'h0001);
    wr(1'b0, 8'h26, 16'hffff);
    rd(1'b0, 8'h26, 16'h1105);
    // Each link bit alone must raise only its own enable.
    for (i = 0; i < 4; i++) begin
      wr(1'b0, 8'h26, 16'h0001 << pos[i]);
      en = {tmo_en, pmb_en, fast_en, rdbk_en};
      chk({12'h000, en}, 16'h0008 >> i);
    end
    $display("Test registers done");
  endtask

  // PMBus aliases are refused while disabled and work once enabled.
  task automatic t_pmbus();
    wr(1'b0, 8'h26, 16'h0000);
    wr(1'b1, 8'he9, 16'h0100);
    rd(1'b0, 8'h25, 16'h231f);
    wr(1'b0, 8'h26, 16'h0100);
    wr(1'b1, 8'he9, 16'h0200);
    rd(1'b0, 8'h25, 16'h0200);
    wr(1'b1, 8'hef, 16'h0042);
    rd(1'b0, 8'h2b, 16'h0042);
    rd(1'b1, 8'he9, 16'h0200);
    wr(1'b0, 8'h25, 16'h0000);
    $display("Test pmbus done");
  endtask

  // The pointer wraps from the top location and a read leaves it alone.
  task automatic t_sram();
    wr(1'b0, 8'h2b, 16'hfffe);
    rd(1'b0, 8'h2b, 16'h00fe);
    wr(1'b0, 8'h2c, 16'ha5a5);
    wr(1'b0, 8'h2c, 16'h5a5a);
    wr(1'b0, 8'h2c, 16'h1234);
    rd(1'b0, 8'h2b, 16'h0001);
    wr(1'b0, 8'h2b, 16'h00ff);
    rd(1'b0, 8'h2c, 16'h5a5a);
    rd(1'b0, 8'h2b, 16'h00ff);
    $display("Test scratch done");
  endtask

  // A falling edge under another pin function must not fire protect.
  task automatic t_pinfn();
    @(posedge i_clk);
    gp_pin <= 1'b0;
    repeat (3) @(posedge i_clk);
    gp_pin <= 1'b1;
    pin_fn <= 4'h5;
    @(negedge i_clk);
    chk({15'h0000, hiz}, 16'h0000);
    $display("Test pin function done");
  endtask

  // One protect action: fire on a falling pin edge, then leave power-down.
  task automatic t_prot(input logic [1:0] act);
    int n;
    wr(1'b0, 8'h25, {6'h00, act, 8'h00});
    @(posedge i_clk);
    gp_pin <= 1'b0;
    @(negedge i_clk);
    for (n = 0; n < 8 && !(hiz || slew_req || tgt != MDCFG_TGT_NONE); n++) begin
      @(negedge i_clk);
    end
    if (act == 2'h0) begin
      chk({13'h0000, slew_req, hiz, 1'b0}, {13'h0000, 3'h2});
      chk({14'h0000, tgt}, 16'h0000);
    end else if (act == 2'h1) begin
      chk({13'h0000, slew_req, tgt}, 16'h0001);
      @(negedge i_clk);
      chk({15'h0000, hiz}, 16'h0001);
    end else begin
      chk({12'h000, slew_req, hiz, tgt}, {12'h000, 2'h2, act});
      repeat (3) @(negedge i_clk);
      chk({12'h000, slew_req, hiz, tgt}, {12'h000, 2'h2, act});
      @(posedge i_clk);
      slew_done <= 1'b1;
      @(posedge i_clk);
      slew_done <= 1'b0;
      @(negedge i_clk);
      chk({14'h0000, slew_req, hiz}, 16'h0001);
    end
    @(posedge i_clk);
    gp_pin <= 1'b1;
    wr(1'b0, 8'h25, 16'h0000);
    chk({13'h0000, hiz, tgt}, 16'h0000);
    $display("Test protect %0d done", act);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    i_reset_n = 1'b0;
    gp_pin = 1'b1;
    pin_fn = 4'h4;
    slew_done = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'b1;
    t_regs();
    t_pmbus();
    t_sram();
    t_pinfn();
    for (int a = 0; a < 4; a++) begin
      t_prot(a[1:0]);
    end
    close_out();
  end

  // The run needs well under 1000 cycles; 4000 cycles means a hang.
  initial begin
    #100000;
    error_cnt++;
    close_out();
  end
endmodule
